// ==== logic/pbs_sram_port.sv ====
`timescale 1ns/1ps
module pbs_sram_port #(
  parameter int LANES = pbs_pkg::LANES_DEF,
  parameter int ADDR_W = pbs_pkg::ADDR_W_DEF
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_chip_select_primary_n,
  input wire logic i_chip_select_high,
  input wire logic i_chip_select_third_n,
  input wire logic i_all_bytes_write_n,
  input wire logic i_partial_write_enable_n,
  input wire logic [LANES-1:0] i_lane_write_select_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order,
  input wire logic [LANES*pbs_pkg::LANE_BITS-1:0] i_lane_data_bits,
  input wire logic [LANES-1:0] i_lane_parity_bit,
  output logic [LANES*pbs_pkg::LANE_BITS-1:0] o_lane_data_bits,
  output logic [LANES-1:0] o_lane_parity_bit,
  output logic [LANES-1:0] o_lane_oe_n,
  output logic o_sleeping,
  input wire logic i_test_clk,
  input wire logic i_test_data_in,
  input wire logic i_test_mode_sel,
  output logic o_test_data_out,
  output logic o_test_data_oe_n
);
  import pbs_pkg::*;
  localparam int LW = LANE_BITS + 1;

  // ------------------------------------------------------------
  // asynchronous pins into the clock domain
  // ------------------------------------------------------------
  logic [5:0] async_m_reg;
  logic [5:0] async_s_reg;
  logic tck_d_reg;
  logic oe_s;
  logic sleep_s;
  logic order_s;
  logic tck_s;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      async_m_reg <= 6'h03;
      async_s_reg <= 6'h03;
      tck_d_reg <= 1'b0;
    end else begin
      async_m_reg <= {i_test_mode_sel, i_test_data_in, i_test_clk, i_burst_order,
                      i_sleep_request, i_output_enable_n};
      async_s_reg <= async_m_reg;
      tck_d_reg <= tck_s;
    end
  end

  assign oe_s = async_s_reg[0];
  assign sleep_s = async_s_reg[1];
  assign order_s = async_s_reg[2];
  assign tck_s = async_s_reg[3];

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  logic [LANES*LW-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] addr_reg;
  logic [BURST_W-1:0] cnt_reg;
  logic [BURST_W-1:0] cnt_next;
  logic active_reg;
  logic sel;
  logic p_go;
  logic c_go;
  logic start;
  logic open_acc;
  logic cont;
  logic wr_req;
  logic do_read;
  logic [BURST_W-1:0] base_lo;
  logic [BURST_W-1:0] off;
  logic [ADDR_W-1:0] acc_addr;
  logic [LANES-1:0] lane_sel;
  logic [LANES-1:0] lane_we;

  assign sel = !i_chip_select_primary_n && i_chip_select_high && !i_chip_select_third_n;
  assign p_go = !i_processor_addr_strobe_n && !i_chip_select_primary_n && !sleep_s;
  assign c_go = !i_controller_addr_strobe_n && !p_go && !sleep_s;
  assign start = p_go || c_go;
  assign open_acc = start && sel;
  assign cont = active_reg && !start && !sleep_s;

  always_comb begin
    if (!i_all_bytes_write_n) begin
      lane_sel = '1;
    end else if (!i_partial_write_enable_n) begin
      lane_sel = ~i_lane_write_select_n;
    end else begin
      lane_sel = '0;
    end
  end

  assign wr_req = |lane_sel;
  // processor-strobe cycles ignore the write controls
  assign lane_we = ((open_acc && !p_go) || cont) ? lane_sel : '0;
  assign do_read = (open_acc && (p_go || !wr_req)) || (cont && !wr_req);

  always_comb begin
    if (open_acc) begin
      cnt_next = BURST_START;
    end else if (cont && !i_burst_advance_n) begin
      cnt_next = cnt_reg + 2'h1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  assign base_lo = open_acc ? i_addr[BURST_W-1:0] : addr_reg[BURST_W-1:0];
  assign off = order_s ? (base_lo ^ cnt_next) : (base_lo + cnt_next);
  assign acc_addr = {open_acc ? i_addr[ADDR_W-1:BURST_W] : addr_reg[ADDR_W-1:BURST_W], off};

  // ------------------------------------------------------------
  // address and burst state
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      addr_reg <= '0;
      cnt_reg <= BURST_START;
      active_reg <= 1'b0;
    end else begin
      if (open_acc) addr_reg <= i_addr;
      cnt_reg <= cnt_next;
      if (start) active_reg <= sel;
    end
  end

  // ------------------------------------------------------------
  // memory: written at the edge, never reset
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (lane_we[l]) begin
        mem[acc_addr][l*LW +: LW] <= {i_lane_parity_bit[l],
                                      i_lane_data_bits[l*LANE_BITS +: LANE_BITS]};
      end
    end
  end

  // ------------------------------------------------------------
  // read pipeline
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr_reg;
  logic rd_pend_reg;
  logic q_valid_reg;
  logic mask_reg;
  logic [LANES*LW-1:0] q_reg;
  logic drive;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_addr_reg <= '0;
      rd_pend_reg <= 1'b0;
      q_valid_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      rd_addr_reg <= acc_addr;
      rd_pend_reg <= do_read;
      q_valid_reg <= rd_pend_reg;
      mask_reg <= open_acc && !active_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q_reg <= '0;
    end else begin
      q_reg <= mem[rd_addr_reg];
    end
  end

  // write controls seen live force the drivers off
  assign drive = q_valid_reg && !mask_reg && !oe_s && !sleep_s && !wr_req;

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      o_lane_data_bits[l*LANE_BITS +: LANE_BITS] = q_reg[l*LW +: LANE_BITS];
      o_lane_parity_bit[l] = q_reg[l*LW + LANE_BITS];
      o_lane_oe_n[l] = !drive;
    end
  end

  assign o_sleeping = sleep_s;

  // ------------------------------------------------------------
  // test access port
  // ------------------------------------------------------------
  pbs_tap_if tif ();

  assign tif.rise = tck_s && !tck_d_reg;
  assign tif.fall = !tck_s && tck_d_reg;
  assign tif.tdi = async_s_reg[4];
  assign tif.tms = async_s_reg[5];
  assign o_test_data_out = tif.tdo;
  assign o_test_data_oe_n = !tif.tdo_en;

  pbs_tap u_tap (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .t(tif.tap)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_processor_addr_strobe_n_ignored;
    @(posedge i_clk) disable iff (i_srst)
      (!i_processor_addr_strobe_n && i_chip_select_primary_n && i_controller_addr_strobe_n)
      |=> $stable(addr_reg) && $stable(active_reg);
  endproperty
  a_processor_addr_strobe_n_ignored: assert property (p_processor_addr_strobe_n_ignored) else $error("processor_addr_strobe_n not ignored");

  property p_load;
    @(posedge i_clk) disable iff (i_srst)
      (start && sel) |=> addr_reg == $past(i_addr) && cnt_reg == BURST_START && active_reg;
  endproperty
  a_load: assert property (p_load) else $error("strobe load wrong");

  property p_advance;
    @(posedge i_clk) disable iff (i_srst)
      (cont && !i_burst_advance_n) |=> cnt_reg == $past(cnt_reg) + 2'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("burst did not advance");

  property p_both_strobes;
    @(posedge i_clk) disable iff (i_srst)
      (!i_processor_addr_strobe_n && !i_controller_addr_strobe_n && !i_chip_select_primary_n
       && !sleep_s) |-> lane_we == '0;
  endproperty
  a_both_strobes: assert property (p_both_strobes) else $error("controller_addr_strobe_n acted with processor_addr_strobe_n");

  property p_deselect;
    @(posedge i_clk) disable iff (i_srst)
      (start && !sel) |=> (!active_reg && !rd_pend_reg) ##1 !q_valid_reg;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect not taken");

  property p_first_masked;
    @(posedge i_clk) disable iff (i_srst)
      (open_acc && !active_reg) |=> o_lane_oe_n == '1;
  endproperty
  a_first_masked: assert property (p_first_masked) else $error("drove in first cycle");

  property p_write_off;
    @(posedge i_clk) disable iff (i_srst)
      (!i_all_bytes_write_n || (!i_partial_write_enable_n && !(&i_lane_write_select_n)))
      |-> o_lane_oe_n == '1;
  endproperty
  a_write_off: assert property (p_write_off) else $error("drove during write");

  property p_oe_high;
    @(posedge i_clk) disable iff (i_srst)
      (oe_s || sleep_s) |-> o_lane_oe_n == '1;
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("drove with oe high");

  property p_read_latency;
    @(posedge i_clk) disable iff (i_srst)
      do_read |=> ##1 q_valid_reg;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data late");
endmodule // pbs_sram_port

// ==== logic/pbs_pkg.sv ====
package pbs_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int LANE_BITS = 8;
  localparam int LANES_DEF = 4;
  localparam int ADDR_W_DEF = 19;
  localparam int BURST_W = 2;
  localparam int IR_W = 2;
  localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  // ------------------------------------------------------------
  // test access port states
  // ------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHF_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHF_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } pbs_tap_state_type;
endpackage

// ==== logic/pbs_tap_if.sv ====
`timescale 1ns/1ps
interface pbs_tap_if;
  logic rise;
  logic fall;
  logic tdi;
  logic tms;
  logic tdo;
  logic tdo_en;
  modport core (output rise, output fall, output tdi, output tms, input tdo, input tdo_en);
  modport tap (input rise, input fall, input tdi, input tms, output tdo, output tdo_en);
endinterface

// ==== logic/pbs_tap.sv ====
`timescale 1ns/1ps
module pbs_tap (
  input wire logic i_clk,
  input wire logic i_srst,
  pbs_tap_if.tap t
);
  import pbs_pkg::*;
  pbs_tap_state_type state_reg;
  pbs_tap_state_type state_next;
  logic bypass_reg;
  logic [IR_W-1:0] ir_reg;
  logic tdo_reg;
  logic tdo_en_reg;

  // ------------------------------------------------------------
  // state steering by mode select
  // ------------------------------------------------------------
  always_comb begin
    case (state_reg)
      TAP_RESET: state_next = t.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_next = t.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_next = t.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_next = t.tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_SHF_DR: state_next = t.tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_EX1_DR: state_next = t.tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: state_next = t.tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: state_next = t.tms ? TAP_UPD_DR : TAP_SHF_DR;
      TAP_UPD_DR: state_next = t.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_next = t.tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_next = t.tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_SHF_IR: state_next = t.tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_EX1_IR: state_next = t.tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: state_next = t.tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: state_next = t.tms ? TAP_UPD_IR : TAP_SHF_IR;
      TAP_UPD_IR: state_next = t.tms ? TAP_SEL_DR : TAP_IDLE;
      default: state_next = TAP_RESET;
    endcase
  end

  // sample on test clock rise
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= TAP_RESET;
    end else if (t.rise) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bypass_reg <= 1'b0;
      ir_reg <= IR_CAPTURE;
    end else if (t.rise) begin
      if (state_reg == TAP_CAP_DR) bypass_reg <= 1'b0;
      if (state_reg == TAP_SHF_DR) bypass_reg <= t.tdi;
      if (state_reg == TAP_CAP_IR) ir_reg <= IR_CAPTURE;
      if (state_reg == TAP_SHF_IR) ir_reg <= {t.tdi, ir_reg[IR_W-1:1]};
    end
  end

  // update serial output on test clock fall
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tdo_reg <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else if (t.fall) begin
      tdo_reg <= (state_reg == TAP_SHF_DR) ? bypass_reg : ir_reg[0];
      tdo_en_reg <= (state_reg == TAP_SHF_DR) || (state_reg == TAP_SHF_IR);
    end
  end

  assign t.tdo = tdo_reg;
  assign t.tdo_en = tdo_en_reg;

  property p_tdo_on_fall;
    @(posedge i_clk) disable iff (i_srst) !t.fall |=> $stable(tdo_reg) && $stable(tdo_en_reg);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved without fall");

  property p_state_on_rise;
    @(posedge i_clk) disable iff (i_srst) !t.rise |=> $stable(state_reg);
  endproperty
  a_state_on_rise: assert property (p_state_on_rise) else $error("tap moved without rise");
endmodule // pbs_tap

// ==== testbench/pbs_host_model.sv ====
`timescale 1ns/1ps
module pbs_host_model #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic [35:0] i_dev_bus,
  input wire logic [3:0] i_dev_oe_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_processor_addr_strobe_n,
  output logic o_controller_addr_strobe_n,
  output logic o_burst_advance_n,
  output logic o_chip_select_primary_n,
  output logic o_chip_select_high,
  output logic o_chip_select_third_n,
  output logic o_all_bytes_write_n,
  output logic o_partial_write_enable_n,
  output logic [3:0] o_lane_write_select_n,
  output logic o_output_enable_n,
  output logic o_sleep_request,
  output logic o_burst_order,
  output logic [35:0] o_bus
);
  logic [35:0] wdat = 36'h0;
  logic hdrv = 1'b0;
  logic [35:0] last_reg = 36'h0;
  logic [35:0] dev_m;
  // ------------------------------------------------------------
  // shared data wire
  // ------------------------------------------------------------
  // lanes nobody drives float: show inverse of last level
  assign dev_m = {~i_dev_oe_n, {8{~i_dev_oe_n[3]}}, {8{~i_dev_oe_n[2]}},
                  {8{~i_dev_oe_n[1]}}, {8{~i_dev_oe_n[0]}}};
  assign o_bus = (dev_m & i_dev_bus) | (~dev_m & (hdrv ? wdat : ~last_reg));
  always_ff @(posedge i_clk) begin
    last_reg <= o_bus;
  end
  // ------------------------------------------------------------
  // bus cycles, entered at a falling edge
  // ------------------------------------------------------------
  // ctl: proc strobe, ctrl strobe, advance, select, all write, partial enable
  task automatic put(input logic [5:0] ctl, input logic [3:0] bwn,
                     input logic [ADDR_W-1:0] a, input logic [35:0] w);
    o_processor_addr_strobe_n = ctl[5];
    o_controller_addr_strobe_n = ctl[4];
    o_burst_advance_n = ctl[3];
    o_chip_select_primary_n = ~ctl[2];
    o_chip_select_high = ctl[2];
    o_chip_select_third_n = ~ctl[2];
    o_all_bytes_write_n = ctl[1];
    o_partial_write_enable_n = ctl[0];
    o_lane_write_select_n = bwn;
    o_addr = a;
    wdat = w;
    hdrv = ~(ctl[1] & ctl[0]);
  endtask
  task automatic cyc(input logic [5:0] ctl, input logic [3:0] bwn,
                     input logic [ADDR_W-1:0] a, input logic [35:0] w);
    put(ctl, bwn, a, w);
    @(negedge i_clk);
  endtask
  // strap and async pins change only with the bus idle
  task automatic pins(input logic oe_n, input logic zz, input logic md);
    o_output_enable_n = oe_n;
    o_sleep_request = zz;
    o_burst_order = md;
    repeat (4) cyc(6'h3F, 4'hF, '0, '0);
  endtask
  initial begin
    put(6'h3F, 4'hF, '0, '0);
    o_output_enable_n = 1'b1;
    o_sleep_request = 1'b0;
    o_burst_order = 1'b0;
  end
endmodule  // pbs_host_model

// ==== testbench/tb_pipelined_burst_sram_port.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_pipelined_burst_sram_port;
  import pbs_pkg::*;
  localparam logic [5:0] IDL = 6'h3F;
  localparam logic [5:0] RDC = 6'h2F;
  localparam logic [5:0] ALLW = 6'h2D;
  localparam logic [5:0] SELW = 6'h2E;
  localparam logic [5:0] STP = 6'h37;
  localparam logic [5:0] DSL = 6'h2B;
  localparam logic [5:0] PSX = 6'h1B;
  localparam logic [5:0] BTH = 6'h0D;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  int num_errors = 0;
  int checks = 0;
  logic [35:0] bus, rd;
  logic [3:0] oe_n, bw_n;
  logic [7:0] addr;
  logic ps_n, cs_n, adv_n, c1_n, c2, c3_n, gw_n, bwe_n, oe_pin_n, zz, md, slp;
  logic [35:0] mem [256];
  logic tck = 1'b0, tdi = 1'b0, tms = 1'b0, tdo, tdo_oe_n;
  // ------------------------------------------------------------
  // clock, device and host
  // ------------------------------------------------------------
  initial forever #4 i_clk = ~i_clk;
  pbs_sram_port #(.LANES(4), .ADDR_W(8)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(addr),
    .i_processor_addr_strobe_n(ps_n), .i_controller_addr_strobe_n(cs_n),
    .i_burst_advance_n(adv_n), .i_chip_select_primary_n(c1_n),
    .i_chip_select_high(c2), .i_chip_select_third_n(c3_n),
    .i_all_bytes_write_n(gw_n), .i_partial_write_enable_n(bwe_n),
    .i_lane_write_select_n(bw_n), .i_output_enable_n(oe_pin_n), .i_sleep_request(zz),
    .i_burst_order(md), .i_lane_data_bits(bus[31:0]), .i_lane_parity_bit(bus[35:32]),
    .o_lane_data_bits(rd[31:0]), .o_lane_parity_bit(rd[35:32]), .o_lane_oe_n(oe_n),
    .o_sleeping(slp), .i_test_clk(tck), .i_test_data_in(tdi), .i_test_mode_sel(tms),
    .o_test_data_out(tdo), .o_test_data_oe_n(tdo_oe_n)
  );
  pbs_host_model #(.ADDR_W(8)) host (
    .i_clk(i_clk), .i_dev_bus(rd), .i_dev_oe_n(oe_n), .o_addr(addr),
    .o_processor_addr_strobe_n(ps_n), .o_controller_addr_strobe_n(cs_n),
    .o_burst_advance_n(adv_n), .o_chip_select_primary_n(c1_n),
    .o_chip_select_high(c2), .o_chip_select_third_n(c3_n),
    .o_all_bytes_write_n(gw_n), .o_partial_write_enable_n(bwe_n),
    .o_lane_write_select_n(bw_n), .o_output_enable_n(oe_pin_n),
    .o_sleep_request(zz), .o_burst_order(md), .o_bus(bus)
  );
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [35:0] w);
    host.cyc(ALLW, 4'hF, a, w);
    mem[a] = w;
  endtask
  task automatic rdchk(input logic [7:0] a);
    host.cyc(RDC, 4'hF, a, '0);
    host.cyc(IDL, 4'hF, a, '0);
    `CHK(rd, mem[a])
    `CHK(oe_n, 4'h0)
  endtask
  task automatic t_reset();
    `CHK(oe_n, 4'hF)
    host.pins(1'b0, 1'b0, 1'b0);
    `CHK(slp, 1'b0)
  endtask
  task automatic t_global();
    wr(8'h10, 36'hF_1234_5678);
    wr(8'h11, 36'h0_CAFE_F00D);
    rdchk(8'h10);
    rdchk(8'h11);
    host.pins(1'b1, 1'b0, 1'b0);
    host.cyc(RDC, 4'hF, 8'h10, '0);
    host.cyc(IDL, 4'hF, 8'h10, '0);
    `CHK(oe_n, 4'hF)
    host.pins(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_partial();
    logic [35:0] m;
    m = 36'h5_00FF_00FF;
    host.put(SELW, 4'hA, 8'h10, 36'hF_A5A5_5A5A);
    #1;
    `CHK(oe_n, 4'hF)
    @(negedge i_clk);
    mem[8'h10] = (mem[8'h10] & ~m) | (36'hF_A5A5_5A5A & m);
    rdchk(8'h10);
  endtask
  task automatic t_burst(input logic mode);
    logic [1:0] off;
    host.pins(1'b0, 1'b0, mode);
    for (int k = 0; k < 4; k++) begin
      wr(8'h40 + 8'(k), 36'h9_8765_4300 | 36'(k));
    end
    for (int j = 0; j < 5; j++) begin
      host.cyc((j == 0) ? RDC : ((j < 4) ? STP : IDL), 4'hF, 8'h41, '0);
      if (j > 0) begin
        off = mode ? (2'h1 ^ 2'(j - 1)) : (2'h1 + 2'(j - 1));
        `CHK(rd, mem[{6'h10, off}])
      end
    end
  endtask
  task automatic t_desel();
    host.cyc(DSL, 4'hF, 8'h10, '0);
    `CHK(oe_n, 4'h0)
    host.cyc(IDL, 4'hF, 8'h10, '0);
    `CHK(oe_n, 4'hF)
    host.cyc(IDL, 4'hF, 8'h10, '0);
    host.cyc(RDC, 4'hF, 8'h10, '0);
    `CHK(oe_n, 4'hF)
    host.cyc(IDL, 4'hF, 8'h10, '0);
    `CHK(rd, mem[8'h10])
    host.cyc(PSX, 4'hF, 8'h11, '0);
    host.cyc(IDL, 4'hF, 8'h11, '0);
    `CHK(oe_n, 4'h0)
    `CHK(rd, mem[8'h10])
  endtask
  task automatic t_both();
    host.cyc(BTH, 4'hF, 8'h11, 36'h0);
    host.cyc(IDL, 4'hF, 8'h11, '0);
    `CHK(rd, mem[8'h11])
    rdchk(8'h11);
  endtask
  task automatic t_sleep();
    host.pins(1'b0, 1'b1, 1'b0);
    `CHK(slp, 1'b1)
    host.cyc(ALLW, 4'hF, 8'h11, 36'h0);
    host.pins(1'b0, 1'b0, 1'b0);
    `CHK(slp, 1'b0)
    rdchk(8'h11);
  endtask
  task automatic jhalf(input logic ck, input logic ms, input logic di);
    tck = ck;
    tms = ms;
    tdi = di;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic t_tap();
    jhalf(1'b1, 1'b0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      jhalf(1'b0, s < 2, 1'b0);
      jhalf(1'b1, s < 2, 1'b0);
    end
    jhalf(1'b0, 1'b0, 1'b1);
    `CHK(tdo, IR_CAPTURE[0])
    `CHK(tdo_oe_n, 1'b0)
    jhalf(1'b1, 1'b0, 1'b1);
    `CHK(tdo, IR_CAPTURE[0])
    jhalf(1'b0, 1'b0, 1'b0);
    `CHK(tdo, IR_CAPTURE[1])
    jhalf(1'b1, 1'b0, 1'b0);
    jhalf(1'b0, 1'b1, 1'b0);
    `CHK(tdo, 1'b1)
    jhalf(1'b1, 1'b1, 1'b0);
    jhalf(1'b0, 1'b1, 1'b0);
    `CHK(tdo_oe_n, 1'b1)
    jhalf(1'b1, 1'b1, 1'b0);
    jhalf(1'b0, 1'b0, 1'b0);
    jhalf(1'b1, 1'b0, 1'b0);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (3) @(negedge i_clk);
    t_reset();
    t_tap();
    t_global();
    t_partial();
    t_burst(1'b0);
    t_burst(1'b1);
    t_desel();
    t_both();
    t_sleep();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    wrap_up();
  end
endmodule  // tb_pipelined_burst_sram_port
